// ==== src/pic_regs.vh ====
// Register offsets, field positions and reset values of the port ingress classify registers
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// Byte offsets inside one port space, port number in the top nibble
`define PIC_OFS_TAG_FILTER   12'h802
`define PIC_OFS_AUTH_ACL     12'h803
`define PIC_OFS_POINTER      12'h804
`define PIC_OFS_PRIO_MAP     12'h808

// Port number that this register set answers to
`define PIC_PORT_NUM         4'h1

// Ingress tag filter control fields
`define PIC_TF_CEILING       7
`define PIC_TF_DROP_UNTAG    4
`define PIC_TF_DROP_TAG      3
`define PIC_TF_DPRIO_HI      2
`define PIC_TF_DPRIO_LO      0
`define PIC_TF_RST           8'h00

// Auth and ACL mode control fields
`define PIC_AM_ACL_EN        2
`define PIC_AM_MODE_HI       1
`define PIC_AM_MODE_LO       0
`define PIC_AM_MODE_RST      2'h0

// Authentication mode encodings
`define PIC_MODE_PASS0       2'h0
`define PIC_MODE_BLOCK       2'h1
`define PIC_MODE_PASS1       2'h2
`define PIC_MODE_TRAP        2'h3

// Indirect pointer fields
`define PIC_PT_PIDX_HI       18
`define PIC_PT_PIDX_LO       16
`define PIC_PT_QPTR_HI       1
`define PIC_PT_QPTR_LO       0
`define PIC_PT_PIDX_RST      3'h0
`define PIC_PT_QPTR_RST      2'h0

// Priority map: 4-bit field per priority, queue in the low two bits
`define PIC_MAP_FIELD_W      4
`define PIC_MAP_QUEUE_W      2
// Packed 2-bit queues, priority 7 at the top: 3,3,2,2,1,1,0,0
`define PIC_MAP_RST          16'hFA50

`endif

// ==== src/pic_classify.v ====
// Per-frame ingress decision: drop, host trap, priority, ceiling and queue
`timescale 1ns/100ps

module pic_classify
(
  input  wire        ceiling_en,
  input  wire        drop_untag,
  input  wire        drop_tag,
  input  wire [2:0]  default_prio,
  input  wire [1:0]  auth_mode,
  input  wire        acl_enabled,
  input  wire [15:0] queue_map,
  input  wire        frm_tagged,
  input  wire [2:0]  frm_user_prio,
  input  wire        frm_class_hit,
  input  wire [2:0]  frm_class_prio,
  input  wire [2:0]  default_tag_prio,
  input  wire        acl_hit,
  input  wire        acl_rule_drop,
  output reg         next_drop,
  output reg         next_to_host,
  output reg  [2:0]  next_prio,
  output reg  [2:0]  next_user_prio,
  output reg  [1:0]  next_queue
);

`include "pic_regs.vh"

  // Queue of one priority out of the packed map
  function [1:0] pic_queue_of;
    input [15:0] map;
    input [2:0]  prio;
    begin
      pic_queue_of = map[{prio, 1'b0} +: `PIC_MAP_QUEUE_W];
    end
  endfunction

  reg miss_blocks;

  // Decision for the frame now presented
  always @*
  begin
    miss_blocks = 1'b0;
    if (ceiling_en && frm_tagged && (frm_user_prio > default_tag_prio))
      next_user_prio = default_tag_prio;
    else
      next_user_prio = frm_user_prio;
    if (frm_class_hit)
      next_prio = frm_class_prio;
    else
      next_prio = default_prio;
    // Priority picks the transmit queue
    next_queue = pic_queue_of(queue_map, next_prio);
    case (auth_mode)
      `PIC_MODE_PASS0: miss_blocks = 1'b0;
      `PIC_MODE_PASS1: miss_blocks = 1'b0;
      `PIC_MODE_BLOCK: miss_blocks = 1'b1;
      `PIC_MODE_TRAP:  miss_blocks = 1'b1;
      default:         miss_blocks = 1'b0;
    endcase
    next_to_host = (auth_mode == `PIC_MODE_TRAP);
    next_drop = (drop_untag && !frm_tagged) || (drop_tag && frm_tagged);
    // ACL hit follows rule action, miss follows the mode
    if (acl_enabled)
    begin
      if (acl_hit)
        next_drop = next_drop || acl_rule_drop;
      else
        next_drop = next_drop || miss_blocks;
    end
  end

endmodule

// ==== src/pic_top.v ====
// Port ingress classify register set with per-frame decision output
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps

module pic_top
(
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        acl_enable_in,
  input  wire        frm_valid,
  input  wire        frm_tagged,
  input  wire [2:0]  frm_user_prio,
  input  wire        frm_class_hit,
  input  wire [2:0]  frm_class_prio,
  input  wire [2:0]  default_tag_prio,
  input  wire        acl_hit,
  input  wire        acl_rule_drop,
  output reg         res_valid,
  output reg         res_drop,
  output reg         res_to_host,
  output reg  [2:0]  res_prio,
  output reg  [2:0]  res_user_prio,
  output reg  [1:0]  res_queue,
  output reg  [2:0]  port_index,
  output reg  [1:0]  queue_pointer
);

`include "pic_regs.vh"

  // Widen the packed queue map to its 32-bit register image
  function [31:0] pic_map_image;
    input [15:0] map;
    integer      i;
    begin
      pic_map_image = 32'h00000000;
      for (i = 0; i < 8; i = i + 1)
      begin
        pic_map_image[i * `PIC_MAP_FIELD_W +: `PIC_MAP_QUEUE_W] = map[i * `PIC_MAP_QUEUE_W +: `PIC_MAP_QUEUE_W];
      end
    end
  endfunction

  // Pack the queue bits of a written 32-bit image, reserved bits dropped
  function [15:0] pic_map_pack;
    input [31:0] img;
    integer      i;
    begin
      pic_map_pack = 16'h0000;
      for (i = 0; i < 8; i = i + 1)
      begin
        pic_map_pack[i * `PIC_MAP_QUEUE_W +: `PIC_MAP_QUEUE_W] = img[i * `PIC_MAP_FIELD_W +: `PIC_MAP_QUEUE_W];
      end
    end
  endfunction

  // Reset release chain
  reg         rst_meta_n;
  reg         rst_sync_n;

  // Register contents
  reg         ceiling_en;
  reg         drop_untag;
  reg         drop_tag;
  reg  [2:0]  default_prio;
  reg  [1:0]  auth_mode;
  reg         acl_enabled;
  reg  [15:0] queue_map;

  // Address decode
  wire        port_hit;
  wire [11:0] reg_ofs;
  wire        sel_filter;
  wire        sel_auth;
  wire        sel_pointer;
  wire        sel_map;

  // Read path
  reg  [31:0] next_rdata;

  // Frame decision from the classify logic
  wire        next_drop;
  wire        next_to_host;
  wire [2:0]  next_prio;
  wire [2:0]  next_user_prio;
  wire [1:0]  next_queue;

  // Reset is taken at once and released two edges later
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Port nibble must match, the rest is the offset in port space
  assign port_hit    = (reg_addr[15:12] == `PIC_PORT_NUM);
  assign reg_ofs     = reg_addr[11:0];
  assign sel_filter  = port_hit && (reg_ofs == `PIC_OFS_TAG_FILTER);
  assign sel_auth    = port_hit && (reg_ofs == `PIC_OFS_AUTH_ACL);
  assign sel_pointer = port_hit && (reg_ofs == `PIC_OFS_POINTER);
  assign sel_map     = port_hit && (reg_ofs == `PIC_OFS_PRIO_MAP);

  // Tag filter control: ceiling, discards and default priority
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ceiling_en   <= 1'b0;
      drop_untag   <= 1'b0;
      drop_tag     <= 1'b0;
      default_prio <= 3'h0;
    end
    else if (reg_wr && sel_filter)
    begin
      ceiling_en   <= reg_wdata[`PIC_TF_CEILING];
      drop_untag   <= reg_wdata[`PIC_TF_DROP_UNTAG];
      drop_tag     <= reg_wdata[`PIC_TF_DROP_TAG];
      default_prio <= reg_wdata[`PIC_TF_DPRIO_HI:`PIC_TF_DPRIO_LO];
    end
  end

  // Authentication mode, writable part of the auth register
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      auth_mode <= `PIC_AM_MODE_RST;
    end
    else if (reg_wr && sel_auth)
    begin
      auth_mode <= reg_wdata[`PIC_AM_MODE_HI:`PIC_AM_MODE_LO];
    end
  end

  // ACL enable status follows the ACL engine, writes never touch it
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      acl_enabled <= 1'b0;
    end
    else
    begin
      acl_enabled <= acl_enable_in;
    end
  end

  // Indirect port and queue pointers, driven straight to the tables
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      port_index    <= `PIC_PT_PIDX_RST;
      queue_pointer <= `PIC_PT_QPTR_RST;
    end
    else if (reg_wr && sel_pointer)
    begin
      port_index    <= reg_wdata[`PIC_PT_PIDX_HI:`PIC_PT_PIDX_LO];
      queue_pointer <= reg_wdata[`PIC_PT_QPTR_HI:`PIC_PT_QPTR_LO];
    end
  end

  // Priority to queue map, only the queue bits are kept
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      queue_map <= `PIC_MAP_RST;
    end
    else if (reg_wr && sel_map)
    begin
      queue_map <= pic_map_pack(reg_wdata);
    end
  end

  // Read image of the addressed register; unmapped reads as zero
  always @*
  begin
    next_rdata = 32'h00000000;
    if (reg_rd)
    begin
      if (sel_filter)
      begin
        next_rdata[`PIC_TF_CEILING]                  = ceiling_en;
        next_rdata[`PIC_TF_DROP_UNTAG]               = drop_untag;
        next_rdata[`PIC_TF_DROP_TAG]                 = drop_tag;
        next_rdata[`PIC_TF_DPRIO_HI:`PIC_TF_DPRIO_LO] = default_prio;
      end
      else if (sel_auth)
      begin
        next_rdata[`PIC_AM_ACL_EN]                   = acl_enabled;
        next_rdata[`PIC_AM_MODE_HI:`PIC_AM_MODE_LO]  = auth_mode;
      end
      else if (sel_pointer)
      begin
        next_rdata[`PIC_PT_PIDX_HI:`PIC_PT_PIDX_LO]  = port_index;
        next_rdata[`PIC_PT_QPTR_HI:`PIC_PT_QPTR_LO]  = queue_pointer;
      end
      else if (sel_map)
      begin
        next_rdata = pic_map_image(queue_map);
      end
    end
  end

  // Read data stand for the one cycle after the strobe
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // Combinational frame decision from the current settings
  pic_classify pic_classify_i
  (
    .ceiling_en       (ceiling_en),
    .drop_untag       (drop_untag),
    .drop_tag         (drop_tag),
    .default_prio     (default_prio),
    .auth_mode        (auth_mode),
    .acl_enabled      (acl_enabled),
    .queue_map        (queue_map),
    .frm_tagged       (frm_tagged),
    .frm_user_prio    (frm_user_prio),
    .frm_class_hit    (frm_class_hit),
    .frm_class_prio   (frm_class_prio),
    .default_tag_prio (default_tag_prio),
    .acl_hit          (acl_hit),
    .acl_rule_drop    (acl_rule_drop),
    .next_drop        (next_drop),
    .next_to_host     (next_to_host),
    .next_prio        (next_prio),
    .next_user_prio   (next_user_prio),
    .next_queue       (next_queue)
  );

  // Result valid marks the cycle after a frame was presented
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      res_valid <= 1'b0;
    end
    else
    begin
      res_valid <= frm_valid;
    end
  end

  // Decision held for the frame, updated only when one is presented
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      res_drop      <= 1'b0;
      res_to_host   <= 1'b0;
      res_prio      <= 3'h0;
      res_user_prio <= 3'h0;
      res_queue     <= 2'h0;
    end
    else if (frm_valid)
    begin
      res_drop      <= next_drop;
      res_to_host   <= next_to_host;
      res_prio      <= next_prio;
      res_user_prio <= next_user_prio;
      res_queue     <= next_queue;
    end
  end

endmodule

// ==== sim/pic_top_monitor.sv ====
// Concurrent checks on the ports of the port ingress classify registers
`timescale 1ns/100ps

module pic_top_monitor
(
  input wire        sys_clk,
  input wire        rst_n,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        acl_enable_in,
  input wire        frm_valid,
  input wire        frm_tagged,
  input wire [2:0]  frm_user_prio,
  input wire        frm_class_hit,
  input wire [2:0]  default_tag_prio,
  input wire        res_valid,
  input wire        res_drop,
  input wire [2:0]  res_prio,
  input wire [2:0]  res_user_prio,
  input wire [2:0]  port_index,
  input wire [1:0]  queue_pointer
);
  reg  [7:0] filt;
  reg  [7:0] old_filt;
  wire       mapped;

  // Shadow of the tag filter register and the copy a frame saw
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt     <= 8'h00;
      old_filt <= 8'h00;
    end
    else
    begin
      old_filt <= filt;
      if (reg_wr && reg_addr == 16'h1802)
        filt <= reg_wdata[7:0];
    end
  end

  // Decoded register places
  assign mapped = reg_addr == 16'h1802 || reg_addr == 16'h1803 || reg_addr == 16'h1804 || reg_addr == 16'h1808;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Register bus relations
  unmapped_rd_a :
    assert property (reg_rd && !mapped |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  rdata_idle_a :
    assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside its cycle");
  acl_status_a :
    assert property (reg_rd && reg_addr == 16'h1803 |=> reg_rdata[31:2] == {29'h0, $past(acl_enable_in, 2)})
    else $error("bad ACL status bit");
  ptr_write_a :
    assert property (reg_wr && reg_addr == 16'h1804 |=>
      {13'h0, port_index, 14'h0, queue_pointer} == ($past(reg_wdata) & 32'h00070003)) else $error("bad pointer");
  ptr_hold_a :
    assert property (!reg_wr |=> $stable({port_index, queue_pointer})) else $error("pointer moved");

  // Frame decision relations
  res_valid_a :
    assert property (frm_valid |=> res_valid) else $error("missing result");
  untag_drop_a :
    assert property (frm_valid && filt[4] && !frm_tagged |=> res_drop) else $error("untagged kept");
  tag_drop_a :
    assert property (frm_valid && filt[3] && frm_tagged |=> res_drop) else $error("tagged kept");
  dflt_prio_a :
    assert property (frm_valid && !frm_class_hit |=> res_prio == old_filt[2:0]) else $error("bad default prio");
  ceiling_a :
    assert property (frm_valid && frm_tagged && filt[7] && frm_user_prio > default_tag_prio |=>
      res_user_prio == $past(default_tag_prio)) else $error("ceiling not applied");
endmodule

// ==== sim/pic_top_tb.sv ====
// Self-checking bench for the port ingress classify registers
`timescale 1ns/100ps

module pic_top_tb;
  reg         sys_clk;
  reg         rst_n;
  reg  [15:0] reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [31:0] reg_rdata;
  reg         acl_enable_in;
  reg         frm_valid;
  reg         frm_tagged;
  reg  [2:0]  frm_user_prio;
  reg         frm_class_hit;
  reg  [2:0]  frm_class_prio;
  reg  [2:0]  default_tag_prio;
  reg         acl_hit;
  reg         acl_rule_drop;
  wire        res_valid;
  wire        res_drop;
  wire        res_to_host;
  wire [2:0]  res_prio;
  wire [2:0]  res_user_prio;
  wire [1:0]  res_queue;
  wire [2:0]  port_index;
  wire [1:0]  queue_pointer;
  integer     err_count;
  integer     n_checks;
  integer     p;

  pic_top pic_top_i
  (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .acl_enable_in    (acl_enable_in),
    .frm_valid        (frm_valid),
    .frm_tagged       (frm_tagged),
    .frm_user_prio    (frm_user_prio),
    .frm_class_hit    (frm_class_hit),
    .frm_class_prio   (frm_class_prio),
    .default_tag_prio (default_tag_prio),
    .acl_hit          (acl_hit),
    .acl_rule_drop    (acl_rule_drop),
    .res_valid        (res_valid),
    .res_drop         (res_drop),
    .res_to_host      (res_to_host),
    .res_prio         (res_prio),
    .res_user_prio    (res_user_prio),
    .res_queue        (res_queue),
    .port_index       (port_index),
    .queue_pointer    (queue_pointer)
  );

  // Free running 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Compare one value and count it
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  // One-cycle register write
  task wr(input [15:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask

  // One-cycle read, data taken in the following cycle
  task rd(input [15:0] a, input [31:0] e);
  begin
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  end
  endtask

  // Frame f = tag,up,hit,cp,dtp,acl hit,rule drop; e = drop,host,prio,uprio,queue
  task frm(input [12:0] f, input [9:0] e);
  begin
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    {frm_tagged, frm_user_prio, frm_class_hit, frm_class_prio, default_tag_prio, acl_hit, acl_rule_drop} <= f;
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    #1;
    chk({res_valid, res_drop, res_to_host, res_prio, res_user_prio, res_queue}, {1'b1, e});
  end
  endtask

  // Counts and verdict
  task report_and_stop;
  begin
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Main sequence
  initial
  begin
    err_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, acl_enable_in, frm_valid} = 52'h0;
    {frm_tagged, frm_user_prio, frm_class_hit, frm_class_prio, default_tag_prio, acl_hit, acl_rule_drop} = 13'h0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(16'h1802, 32'h0);
    rd(16'h1803, 32'h0);
    rd(16'h1804, 32'h0);
    rd(16'h1808, 32'h33221100);
    rd(16'h1805, 32'h0);
    rd(16'h2808, 32'h0);
    $display("test reset values done");
    wr(16'h1802, 32'h85);
    frm(13'h1C08, 10'h0AA);
    frm(13'h1368, 10'h065);
    // Not the host port, so discard may be set
    wr(16'h1802, 32'h10);
    frm(13'h0000, 10'h200);
    frm(13'h1800, 10'h010);
    wr(16'h1802, 32'h08);
    frm(13'h1800, 10'h210);
    frm(13'h0000, 10'h000);
    $display("test tag filter done");
    wr(16'h1802, 32'h0);
    acl_enable_in <= 1'b1;
    for (p = 0; p < 4; p = p + 1)
    begin
      wr(16'h1803, p);
      rd(16'h1803, 4 + p);
      frm(13'h0, {p[0], p == 3, 8'h0});
      frm(13'h2, {1'b0, p == 3, 8'h0});
      frm(13'h3, {1'b1, p == 3, 8'h0});
    end
    @(posedge sys_clk);
    acl_enable_in <= 1'b0;
    frm(13'h0, 10'h100);
    rd(16'h1803, 32'h3);
    $display("test modes done");
    wr(16'h1803, 32'h0);
    wr(16'h1808, 32'h01230123);
    for (p = 0; p < 8; p = p + 1)
      frm({5'h01, p[2:0], 5'h0}, {2'h0, p[2:0], 3'h0, 2'h3 - p[1:0]});
    wr(16'h1802, 32'hFFFFFFFF);
    rd(16'h1802, 32'h9F);
    wr(16'h1803, 32'hFFFFFFFF);
    rd(16'h1803, 32'h3);
    wr(16'h1804, 32'hFFFFFFFF);
    rd(16'h1804, 32'h70003);
    chk({port_index, queue_pointer}, 5'h1F);
    wr(16'h1808, 32'hFFFFFFFF);
    wr(16'h2808, 32'h0);
    rd(16'h1808, 32'h33333333);
    $display("test map and reserved done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(16'h1808, 32'h33221100);
    rd(16'h1804, 32'h0);
    rd(16'h1802, 32'h0);
    $display("test second reset done");
    report_and_stop;
  end
endmodule

bind pic_top pic_top_monitor pic_top_monitor_i
(
  .sys_clk          (sys_clk),
  .rst_n            (rst_n),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_wr           (reg_wr),
  .reg_rd           (reg_rd),
  .reg_rdata        (reg_rdata),
  .acl_enable_in    (acl_enable_in),
  .frm_valid        (frm_valid),
  .frm_tagged       (frm_tagged),
  .frm_user_prio    (frm_user_prio),
  .frm_class_hit    (frm_class_hit),
  .default_tag_prio (default_tag_prio),
  .res_valid        (res_valid),
  .res_drop         (res_drop),
  .res_prio         (res_prio),
  .res_user_prio    (res_user_prio),
  .port_index       (port_index),
  .queue_pointer    (queue_pointer)
);
